// ### src/domain_pc_pkg.sv
// constants and field layouts for the domain-stage push-constant decoder
// assumes one graphics clock; dwords arrive from the command streamer in order
package domain_pc_pkg;

  localparam logic [2:0] CMD_TYPE_3D = 3'h3;
  localparam logic [1:0] CMD_SUBTYPE_3D = 2'h3;
  localparam logic [2:0] CMD_OPCODE_PIPELINED = 3'h0;
  localparam logic [7:0] SUBOP_PUSH_CONST_DOMAIN = 8'h1a;
  localparam logic [7:0] LEN_DEFAULT = 8'h05;

  localparam int NUM_BUFS = 4;
  localparam int BODY_DWORDS = 6;
  localparam logic [2:0] BODY_LEN01 = 3'h0;
  localparam logic [2:0] BODY_LEN23 = 3'h1;
  localparam logic [2:0] BODY_PTR0 = 3'h2;
  localparam logic [17:0] MAX_UNITS = 18'h00040;
  localparam logic [3:0] SCRATCH_CODE_MAX = 4'hb;
  localparam int TAG_W = 9;
  localparam int TAG_COUNT = 512;
  localparam int TID_W = 24;

  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_DYN_BASE = 3'h1;
  localparam logic [2:0] REG_SCRATCH = 3'h2;
  localparam logic [2:0] REG_BINDING = 3'h3;
  localparam logic [2:0] REG_SAMPLER = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;
  localparam logic [2:0] REG_LEN01 = 3'h6;
  localparam logic [2:0] REG_LEN23 = 3'h7;

  typedef struct packed {
    logic [2:0] cmd_type;
    logic [1:0] sub_type;
    logic [2:0] opcode;
    logic [7:0] sub_opcode;
    logic [7:0] rsvd;
    logic [7:0] length;
  } cmd_header_type;

  typedef struct packed {logic [15:0] hi; logic [15:0] lo;} len_pair_type;
  typedef struct packed {logic [26:0] addr; logic [4:0] low;} ptr_dword_type;

  typedef struct packed {logic [26:0] sampler; logic rsvd; logic [3:0] scratch_size;} hdr3_type;
  typedef struct packed {logic [26:0] binding; logic [4:0] rsvd;} hdr4_type;
  typedef struct packed {logic [21:0] scratch_off; logic rsvd; logic [8:0] tag;} hdr5_type;
  typedef struct packed {logic [7:0] rsvd; logic [23:0] tid;} hdr6_type;
  typedef struct packed {logic snapshot; logic [30:0] rsvd;} hdr7_type;

  typedef struct packed {logic [29:0] rsvd; logic snapshot; logic offset_disable;} ctrl_type;
  typedef struct packed {logic [21:0] base; logic [5:0] rsvd; logic [3:0] size;} scratch_type;
  typedef struct packed {
    logic [27:0] rsvd;
    logic tag_full;
    logic ptr_violation;
    logic over_limit;
    logic busy;
  } status_type;

endpackage

// ### src/domain_pc_if.sv
// carriers between the decoder, its fetch sequencer and its tag allocator
// assumes all ends share one clock
`timescale 1ns/1ps
interface pc_cfg_if;
  import domain_pc_pkg::*;
  logic start;
  logic busy;
  logic offset_disable;
  logic [31:0] dyn_base;
  logic [15:0] len [NUM_BUFS];
  logic [26:0] ptr [NUM_BUFS];
  logic [4:0] mocs;
  modport decoder(output start, offset_disable, dyn_base, len, ptr, mocs, input busy);
  modport fetcher(input start, offset_disable, dyn_base, len, ptr, mocs, output busy);
endinterface // pc_cfg_if

interface tag_if;
  import domain_pc_pkg::*;
  logic alloc;
  logic avail;
  logic [TAG_W-1:0] tag;
  logic retire;
  logic [TAG_W-1:0] retire_tag;
  modport user(output alloc, retire, retire_tag, input avail, tag);
  modport allocator(input alloc, retire, retire_tag, output avail, tag);
endinterface // tag_if

// ### src/pc_fetch_sequencer.sv
// walks the four constant buffers and issues one fetch per enabled buffer
// assumes start is a one-cycle pulse issued only while busy is low
`timescale 1ns/1ps
module pc_fetch_sequencer
(
  input wire logic mclk,
  input wire logic rstn,
  pc_cfg_if.fetcher cfg,
  output logic fetch_valid,
  input wire logic fetch_ready,
  output logic [31:0] fetch_addr,
  output logic [15:0] fetch_units,
  output logic [4:0] fetch_mocs,
  output logic [1:0] fetch_buffer
);
  import domain_pc_pkg::*;

  typedef enum logic [1:0] {fs_idle = 2'b01, fs_run = 2'b10} fetch_state_type;
  fetch_state_type state, next_state;
  logic [15:0] lens [NUM_BUFS], next_lens [NUM_BUFS];
  logic [26:0] ptrs [NUM_BUFS], next_ptrs [NUM_BUFS];
  logic absolute0, next_absolute0;
  logic [31:0] base, next_base;
  logic [2:0] idx, next_idx;
  logic next_valid;
  logic [31:0] next_addr;
  logic [15:0] next_units;
  logic [4:0] next_mocs;
  logic [1:0] next_buffer;
  logic [31:0] aligned;

  assign cfg.busy = (state == fs_run);

  always_comb
  begin
    next_state = state;
    next_lens = lens;
    next_ptrs = ptrs;
    next_absolute0 = absolute0;
    next_base = base;
    next_idx = idx;
    next_valid = fetch_valid;
    next_addr = fetch_addr;
    next_units = fetch_units;
    next_mocs = fetch_mocs;
    next_buffer = fetch_buffer;
    aligned = ptr_dword_type'{addr: ptrs[idx[1:0]], low: '0}; // [RL8]
    case (state)
      fs_idle:
        if (cfg.start)
        begin
          next_lens = cfg.len;
          next_ptrs = cfg.ptr;
          next_absolute0 = cfg.offset_disable;
          next_base = cfg.dyn_base;
          next_mocs = cfg.mocs; // [RL10]
          next_idx = '0;
          next_state = fs_run;
        end
      fs_run:
        if (!fetch_valid || fetch_ready)
        begin
          next_valid = 1'b0;
          if (idx == 3'(NUM_BUFS))
            next_state = fs_idle;
          else
          begin
            next_idx = idx + 3'h1;
            // zero length means the buffer is disabled [RL6]
            if (lens[idx[1:0]] != '0)
            begin
              next_valid = 1'b1;
              next_units = lens[idx[1:0]]; // [RL3]
              next_buffer = idx[1:0];
              // only buffer 0 may be relative to the dynamic base [RL9]
              if (idx == 3'h0 && !absolute0)
                next_addr = base + aligned;
              else
                next_addr = aligned;
            end
          end
        end
      default:
        next_state = fs_idle;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= fs_idle;
      for (int i = 0; i < NUM_BUFS; i++)
      begin
        lens[i] <= '0;
        ptrs[i] <= '0;
      end
      absolute0 <= 1'b0;
      base <= '0;
      idx <= '0;
      fetch_valid <= 1'b0;
      fetch_addr <= '0;
      fetch_units <= '0;
      fetch_mocs <= '0;
      fetch_buffer <= '0;
    end
    else
    begin
      state <= next_state;
      lens <= next_lens;
      ptrs <= next_ptrs;
      absolute0 <= next_absolute0;
      base <= next_base;
      idx <= next_idx;
      fetch_valid <= next_valid;
      fetch_addr <= next_addr;
      fetch_units <= next_units;
      fetch_mocs <= next_mocs;
      fetch_buffer <= next_buffer;
    end
  end
endmodule // pc_fetch_sequencer

// ### src/pc_tag_allocator.sv
// hands out nine-bit tags that stay unique while their thread is outstanding
// assumes retire names only a tag that is currently in use
`timescale 1ns/1ps
module pc_tag_allocator
(
  input wire logic mclk,
  input wire logic rstn,
  tag_if.allocator tags
);
  import domain_pc_pkg::*;

  logic busy [TAG_COUNT], next_busy [TAG_COUNT];
  logic [TAG_W-1:0] ptr, next_ptr;

  // a tag still in use is never handed out again [RL14]
  assign tags.avail = !busy[ptr];
  assign tags.tag = ptr;

  always_comb
  begin
    next_busy = busy;
    next_ptr = ptr;
    if (tags.retire)
      next_busy[tags.retire_tag] = 1'b0;
    if (tags.alloc)
    begin
      next_busy[ptr] = 1'b1;
      next_ptr = ptr + TAG_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < TAG_COUNT; i++)
        busy[i] <= 1'b0;
      ptr <= '0;
    end
    else
    begin
      busy <= next_busy;
      ptr <= next_ptr;
    end
  end
endmodule // pc_tag_allocator

// ### src/domain_stage_push_constant_decode.sv
// push-constant command decoder and thread header former for the domain stage
// assumes command dwords, fetch and dispatch ports all run on mclk
//
// Behaviour
// RL1 - match header fields and sub-opcode 1Ah
// RL2 - length field is dwords minus two
// RL3 - read lengths count 256-bit units
// RL4 - lengths packed low/high in two dwords
// RL5 - sender keeps total length within 64
// RL6 - zero length disables the buffer
// RL7 - sender zeroes pointer of disabled buffer
// RL8 - pointers in bits 31:5, 32-byte aligned
// RL9 - offset disable picks absolute buffer-0 pointer
// RL10 - buffer-0 control field applies to all
// RL11 - sender uses linear memory only
// RL12 - header carries unique thread id, snapshot
// RL13 - scratch offset in 1KB units
// RL14 - nine-bit tag unique among outstanding threads
// RL15 - binding table pointer, low bits reserved
// RL16 - sampler state pointer in dword three
// RL17 - scratch size code limited to 0..11
`timescale 1ns/1ps
module domain_stage_push_constant_decode
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic cmd_valid,
  input wire logic [31:0] cmd_data,
  output logic cmd_ready,
  input wire logic [2:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic fetch_valid,
  input wire logic fetch_ready,
  output logic [31:0] fetch_addr,
  output logic [15:0] fetch_units,
  output logic [4:0] fetch_mocs,
  output logic [1:0] fetch_buffer,
  input wire logic spawn_req,
  output logic spawn_ack,
  input wire logic retire_valid,
  input wire logic [8:0] retire_tag,
  output logic hdr_valid,
  output domain_pc_pkg::hdr3_type hdr_dw3,
  output domain_pc_pkg::hdr4_type hdr_dw4,
  output domain_pc_pkg::hdr5_type hdr_dw5,
  output domain_pc_pkg::hdr6_type hdr_dw6,
  output domain_pc_pkg::hdr7_type hdr_dw7
);
  import domain_pc_pkg::*;

  typedef enum logic [2:0] {
    st_header = 3'b001,
    st_body = 3'b010,
    st_skip = 3'b100
  } dec_state_type;

  function automatic logic is_pc_header(input logic [31:0] dw);
    cmd_header_type h;
    h = dw;
    return h.cmd_type == CMD_TYPE_3D && h.sub_type == CMD_SUBTYPE_3D &&
           h.opcode == CMD_OPCODE_PIPELINED && h.sub_opcode == SUBOP_PUSH_CONST_DOMAIN;
  endfunction

  pc_cfg_if cfg();
  tag_if tags();

  dec_state_type state, next_state;
  logic [8:0] remain, next_remain;
  logic [2:0] idx, next_idx;
  logic [31:0] body [BODY_DWORDS], next_body [BODY_DWORDS];
  logic start, next_start;
  logic accept;
  cmd_header_type cmd_hdr;
  len_pair_type len01, len23;
  ptr_dword_type ptr0_dw;
  logic [17:0] unit_sum;
  logic over_now, violation_now;

  ctrl_type ctrl, next_ctrl;
  logic [31:0] dyn_base, next_dyn_base;
  scratch_type scratch, next_scratch;
  logic [26:0] binding, next_binding;
  logic [26:0] sampler, next_sampler;
  logic over_limit, next_over_limit;
  logic ptr_violation, next_ptr_violation;
  logic [31:0] next_rdata;
  status_type status, clear_bits;

  logic [TID_W-1:0] tid, next_tid;
  logic next_hdr_valid;
  hdr3_type next_dw3;
  hdr4_type next_dw4;
  hdr5_type next_dw5;
  hdr6_type next_dw6;
  hdr7_type next_dw7;

  //////////////////////////////////////////////////////////////////////////////
  // command intake

  assign cmd_hdr = cmd_data;
  // hold the next header until the previous fetch walk has finished
  assign cmd_ready = !(state == st_header && (cfg.busy || start));
  assign accept = cmd_valid && cmd_ready;

  always_comb
  begin
    next_state = state;
    next_remain = remain;
    next_idx = idx;
    next_body = body;
    next_start = 1'b0;
    case (state)
      st_header:
        if (accept)
        begin
          next_remain = 9'(cmd_hdr.length) + 9'h001; // [RL2]
          next_idx = '0;
          for (int i = 0; i < BODY_DWORDS; i++)
            next_body[i] = '0;
          next_state = is_pc_header(cmd_data) ? st_body : st_skip; // [RL1]
        end
      st_body:
        if (accept)
        begin
          if (idx < 3'(BODY_DWORDS))
          begin
            next_body[idx] = cmd_data;
            next_idx = idx + 3'h1;
          end
          next_remain = remain - 9'h001;
          // every body dword is consumed before the next header [RL2]
          if (remain == 9'h001)
          begin
            next_state = st_header;
            next_start = 1'b1;
          end
        end
      st_skip:
        if (accept)
        begin
          next_remain = remain - 9'h001;
          if (remain == 9'h001)
            next_state = st_header;
        end
      default:
        next_state = st_header;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= st_header;
      remain <= '0;
      idx <= '0;
      for (int i = 0; i < BODY_DWORDS; i++)
        body[i] <= '0;
      start <= 1'b0;
    end
    else
    begin
      state <= next_state;
      remain <= next_remain;
      idx <= next_idx;
      body <= next_body;
      start <= next_start;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // field extraction toward the fetch sequencer

  assign len01 = body[BODY_LEN01];
  assign len23 = body[BODY_LEN23];
  assign ptr0_dw = body[BODY_PTR0];
  assign cfg.start = start;
  assign cfg.offset_disable = ctrl.offset_disable;
  assign cfg.dyn_base = dyn_base;
  assign cfg.mocs = ptr0_dw.low; // [RL10]
  assign cfg.len[0] = len01.lo; // [RL4]
  assign cfg.len[1] = len01.hi; // [RL4]
  assign cfg.len[2] = len23.lo; // [RL4]
  assign cfg.len[3] = len23.hi; // [RL4]

  for (genvar g = 0; g < NUM_BUFS; g++)
  begin : g_ptr
    ptr_dword_type pd;
    assign pd = body[BODY_PTR0 + 3'(g)];
    assign cfg.ptr[g] = pd.addr; // [RL8]
  end

  // sender-side limits are only reported, never enforced
  always_comb
  begin
    unit_sum = '0;
    violation_now = 1'b0;
    for (int i = 0; i < NUM_BUFS; i++)
    begin
      unit_sum = unit_sum + 18'(cfg.len[i]);
      if (cfg.len[i] == '0 && cfg.ptr[i] != '0)
        violation_now = 1'b1; // [RL7]
    end
    over_now = unit_sum > MAX_UNITS; // [RL5]
  end

  pc_fetch_sequencer u_fetch
  (
    .mclk(mclk),
    .rstn(rstn),
    .cfg(cfg.fetcher),
    .fetch_valid(fetch_valid),
    .fetch_ready(fetch_ready),
    .fetch_addr(fetch_addr),
    .fetch_units(fetch_units),
    .fetch_mocs(fetch_mocs),
    .fetch_buffer(fetch_buffer)
  );

  //////////////////////////////////////////////////////////////////////////////
  // software registers

  always_comb
  begin
    status = '0;
    status.busy = cfg.busy;
    status.over_limit = over_limit;
    status.ptr_violation = ptr_violation;
    status.tag_full = !tags.avail;
  end

  assign clear_bits = (reg_write && reg_addr == REG_STATUS) ? status_type'(reg_wdata) : '0;

  always_comb
  begin
    next_ctrl = ctrl;
    next_dyn_base = dyn_base;
    next_scratch = scratch;
    next_binding = binding;
    next_sampler = sampler;
    next_rdata = '0;
    if (reg_write)
    begin
      if (reg_addr == REG_CTRL)
      begin
        next_ctrl = '0;
        next_ctrl.offset_disable = reg_wdata[0];
        next_ctrl.snapshot = reg_wdata[1];
      end
      else if (reg_addr == REG_DYN_BASE)
        next_dyn_base = reg_wdata;
      else if (reg_addr == REG_SCRATCH)
      begin
        next_scratch = reg_wdata;
        next_scratch.rsvd = '0;
        if (next_scratch.size > SCRATCH_CODE_MAX)
          next_scratch.size = SCRATCH_CODE_MAX; // [RL17]
      end
      else if (reg_addr == REG_BINDING)
        next_binding = reg_wdata[31:5];
      else if (reg_addr == REG_SAMPLER)
        next_sampler = reg_wdata[31:5];
    end
    // a flag raised in the same cycle as its clear stays set
    next_over_limit = (over_limit && !clear_bits.over_limit) || (start && over_now);
    next_ptr_violation = (ptr_violation && !clear_bits.ptr_violation) ||
                         (start && violation_now);
    if (reg_read)
    begin
      if (reg_addr == REG_CTRL)
        next_rdata = ctrl;
      else if (reg_addr == REG_DYN_BASE)
        next_rdata = dyn_base;
      else if (reg_addr == REG_SCRATCH)
        next_rdata = scratch;
      else if (reg_addr == REG_BINDING)
        next_rdata = hdr4_type'{binding: binding, rsvd: '0};
      else if (reg_addr == REG_SAMPLER)
        next_rdata = {sampler, 5'h00};
      else if (reg_addr == REG_STATUS)
        next_rdata = status;
      else if (reg_addr == REG_LEN01)
        next_rdata = len01;
      else
        next_rdata = len23;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl <= '0;
      dyn_base <= '0;
      scratch <= '0;
      binding <= '0;
      sampler <= '0;
      over_limit <= 1'b0;
      ptr_violation <= 1'b0;
      reg_rdata <= '0;
    end
    else
    begin
      ctrl <= next_ctrl;
      dyn_base <= next_dyn_base;
      scratch <= next_scratch;
      binding <= next_binding;
      sampler <= next_sampler;
      over_limit <= next_over_limit;
      ptr_violation <= next_ptr_violation;
      reg_rdata <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // thread header former

  assign spawn_ack = spawn_req && tags.avail;
  assign tags.alloc = spawn_ack;
  assign tags.retire = retire_valid;
  assign tags.retire_tag = retire_tag;

  pc_tag_allocator u_tags
  (
    .mclk(mclk),
    .rstn(rstn),
    .tags(tags.allocator)
  );

  always_comb
  begin
    next_tid = tid;
    next_hdr_valid = spawn_ack;
    next_dw3 = hdr_dw3;
    next_dw4 = hdr_dw4;
    next_dw5 = hdr_dw5;
    next_dw6 = hdr_dw6;
    next_dw7 = hdr_dw7;
    if (spawn_ack)
    begin
      next_tid = tid + TID_W'(1); // [RL12]
      next_dw3 = '0;
      next_dw3.sampler = sampler; // [RL16]
      next_dw3.scratch_size = scratch.size; // [RL17]
      next_dw4 = '0;
      next_dw4.binding = binding; // [RL15]
      next_dw5 = '0;
      // each tag owns its own slice of the scratch area [RL13]
      next_dw5.scratch_off = scratch.base + 22'({13'h0000, tags.tag} << scratch.size);
      next_dw5.tag = tags.tag; // [RL14]
      next_dw6 = '0;
      next_dw6.tid = tid; // [RL12]
      next_dw7 = '0;
      next_dw7.snapshot = ctrl.snapshot; // [RL12]
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      tid <= '0;
      hdr_valid <= 1'b0;
      hdr_dw3 <= '0;
      hdr_dw4 <= '0;
      hdr_dw5 <= '0;
      hdr_dw6 <= '0;
      hdr_dw7 <= '0;
    end
    else
    begin
      tid <= next_tid;
      hdr_valid <= next_hdr_valid;
      hdr_dw3 <= next_dw3;
      hdr_dw4 <= next_dw4;
      hdr_dw5 <= next_dw5;
      hdr_dw6 <= next_dw6;
      hdr_dw7 <= next_dw7;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  logic [4:0] start_mocs;
  logic [TID_W-1:0] last_tid;
  logic hdr_seen;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      start_mocs <= '0;
      last_tid <= '0;
      hdr_seen <= 1'b0;
    end
    else
    begin
      if (start)
        start_mocs <= cfg.mocs;
      if (hdr_valid)
      begin
        last_tid <= hdr_dw6.tid;
        hdr_seen <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_header_match;
    state == st_header && accept |=> (state == st_body) == $past(is_pc_header(cmd_data));
  endproperty
  a_header_match: assert property (p_header_match) else $error("header match wrong"); // [RL1]

  property p_length_count;
    state == st_header && accept && is_pc_header(cmd_data) && cmd_hdr.length == LEN_DEFAULT
      |=> remain == 9'h006 && !start ##0 (!start [*1]);
  endproperty
  a_length_count: assert property (p_length_count) else $error("length count wrong"); // [RL2]

  property p_units_nonzero;
    fetch_valid |-> fetch_units != '0;
  endproperty
  a_units_nonzero: assert property (p_units_nonzero) else $error("disabled buffer fetched"); // [RL6]

  property p_aligned;
    fetch_valid && (fetch_buffer != 2'h0 || cfg.offset_disable) |-> fetch_addr[4:0] == 5'h00;
  endproperty
  a_aligned: assert property (p_aligned) else $error("fetch address misaligned"); // [RL8]

  property p_mocs_all;
    fetch_valid |-> fetch_mocs == start_mocs;
  endproperty
  a_mocs_all: assert property (p_mocs_all) else $error("control field not shared"); // [RL10]

  property p_tid_step;
    hdr_valid && hdr_seen |-> hdr_dw6.tid == last_tid + TID_W'(1) && hdr_dw6.rsvd == '0;
  endproperty
  a_tid_step: assert property (p_tid_step) else $error("thread id not unique"); // [RL12]

  property p_tag_differs;
    hdr_valid ##1 hdr_valid |-> hdr_dw5.tag != $past(hdr_dw5.tag);
  endproperty
  a_tag_differs: assert property (p_tag_differs) else $error("tag repeated"); // [RL14]

  property p_binding;
    spawn_ack |=> hdr_valid && hdr_dw4.rsvd == '0 && hdr_dw4.binding == $past(binding);
  endproperty
  a_binding: assert property (p_binding) else $error("binding pointer wrong"); // [RL15]

  property p_scratch_code;
    hdr_valid |-> hdr_dw3.scratch_size <= SCRATCH_CODE_MAX && !hdr_dw3.rsvd;
  endproperty
  a_scratch_code: assert property (p_scratch_code) else $error("scratch code out of range"); // [RL17]

  property p_fetch_follows;
    start |=> cfg.busy;
  endproperty
  a_fetch_follows: assert property (p_fetch_follows) else $error("fetch walk not started"); // [RL3]

  c_buffer3: cover property (fetch_valid && fetch_ready && fetch_buffer == 2'h3);
  c_skip: cover property (state == st_skip ##1 state == st_header);
  c_tag_stall: cover property (spawn_req && !spawn_ack);
endmodule // domain_stage_push_constant_decode

// ### test/pc_fetch_responder.sv
// fetch acceptor standing in for the constant fetch memory side
// assumes fetch requests hold until taken; records each taken request
`timescale 1ns/1ps
module pc_fetch_responder
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  input wire logic [15:0] fetch_units,
  input wire logic [4:0] fetch_mocs,
  input wire logic [1:0] fetch_buffer,
  output logic fetch_ready
);
  logic hold;
  logic [54:0] q [$];
  // slow mode stalls every other cycle
  assign fetch_ready = !slow || hold;
  always @(posedge mclk or negedge rstn)
    if (!rstn)
      hold <= 1'b0;
    else
    begin
      hold <= !hold;
      if (fetch_valid && fetch_ready)
        q.push_back({fetch_buffer, fetch_mocs, fetch_units, fetch_addr});
    end
endmodule // pc_fetch_responder

// ### test/domain_stage_push_constant_decode_tb_top.sv
// directed bench for the push-constant decoder
// assumes the fetch responder model and the design package
`timescale 1ns/1ps
module domain_stage_push_constant_decode_tb_top;
  import domain_pc_pkg::*;
  logic mclk = 0, rstn = 0, cmd_valid = 0, reg_write = 0, reg_read = 0;
  logic spawn_req = 0, retire_valid = 0, slow = 0, fetch_ready, cmd_ready, spawn_ack;
  logic fetch_valid, hdr_valid;
  logic [31:0] cmd_data = 0, reg_wdata = 0, reg_rdata, fetch_addr;
  logic [2:0] reg_addr = 0;
  logic [8:0] retire_tag = 0;
  logic [15:0] fetch_units;
  logic [4:0] fetch_mocs;
  logic [1:0] fetch_buffer;
  hdr3_type hdr_dw3;
  hdr4_type hdr_dw4;
  hdr5_type hdr_dw5;
  hdr6_type hdr_dw6;
  hdr7_type hdr_dw7;
  int fails = 0, tests_run = 0;
  always #25 mclk = !mclk;
  domain_stage_push_constant_decode domain_stage_push_constant_decode_inst (.mclk(mclk),
    .rstn(rstn), .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .fetch_valid(fetch_valid), .fetch_ready(fetch_ready),
    .fetch_addr(fetch_addr), .fetch_units(fetch_units), .fetch_mocs(fetch_mocs),
    .fetch_buffer(fetch_buffer), .spawn_req(spawn_req), .spawn_ack(spawn_ack),
    .retire_valid(retire_valid), .retire_tag(retire_tag), .hdr_valid(hdr_valid),
    .hdr_dw3(hdr_dw3), .hdr_dw4(hdr_dw4), .hdr_dw5(hdr_dw5), .hdr_dw6(hdr_dw6),
    .hdr_dw7(hdr_dw7));
  pc_fetch_responder pc_fetch_responder_inst (.mclk(mclk), .rstn(rstn), .slow(slow),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .fetch_units(fetch_units),
    .fetch_mocs(fetch_mocs), .fetch_buffer(fetch_buffer), .fetch_ready(fetch_ready));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    tests_run++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test;
    if (fails == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rdc(input logic [2:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    @(posedge mclk);
    chk("reg_rdata", reg_rdata, e);
  endtask
  task automatic put(input logic [31:0] d);
    int i;
    cmd_valid <= 1'b1;
    cmd_data <= d;
    @(posedge mclk);
    for (i = 0; i < 200 && cmd_ready !== 1'b1; i++)
      @(posedge mclk);
  endtask
  task automatic send(input logic [31:0] h, input logic [31:0] b [6]);
    put(h);
    foreach (b[i])
      put(b[i]);
    cmd_valid <= 1'b0;
  endtask
  task automatic fx(input logic [54:0] e);
    int i;
    for (i = 0; i < 200 && pc_fetch_responder_inst.q.size() == 0; i++)
      @(posedge mclk);
    chk("fetch", pc_fetch_responder_inst.q.pop_front(), e);
  endtask
  task automatic sp(input logic [8:0] tag, input logic [23:0] tid);
    int i;
    spawn_req <= 1'b1;
    @(posedge mclk);
    for (i = 0; i < 100 && spawn_ack !== 1'b1; i++)
      @(posedge mclk);
    spawn_req <= 1'b0;
    #1;
    chk("hdr_valid", hdr_valid, 1);
    chk("hdr_dw5", hdr_dw5, {22'h10 + (22'(tag) << 3), 1'b0, tag});
    chk("hdr_dw6", hdr_dw6, {8'h0, tid});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rdc(REG_CTRL, 0);
    rdc(REG_STATUS, 0);
    wr(REG_DYN_BASE, 32'h1000);
    wr(REG_SCRATCH, 32'h4003);
    wr(REG_BINDING, 32'ha7f);
    wr(REG_SAMPLER, 32'h125f);
    send(32'h781a0005, '{32'h2, 32'h10003, 32'h2047, 0, 32'h3000, 32'h4000});
    rdc(REG_LEN01, 32'h2);
    // offered while the previous walk still runs, held off until it finishes, then swallowed whole
    send(32'h781b0005, '{6{32'hffffffff}});
    fx({2'd0, 5'h07, 16'h2, 32'h3040});
    fx({2'd2, 5'h07, 16'h3, 32'h3000});
    fx({2'd3, 5'h07, 16'h1, 32'h4000});
    slow <= 1'b1;
    wr(REG_CTRL, 32'h3);
    send(32'h781a0005, '{32'h400001, 0, 32'h2049, 32'h5000, 32'h6000, 0});
    fx({2'd0, 5'h09, 16'h1, 32'h2040});
    fx({2'd1, 5'h09, 16'h40, 32'h5000});
    chk("extra_fetch", pc_fetch_responder_inst.q.size(), 0);
    repeat (8) @(posedge mclk);
    rdc(REG_STATUS, 32'h6);
    wr(REG_STATUS, 32'h6);
    rdc(REG_STATUS, 0);
    sp(9'd0, 24'd0);
    sp(9'd1, 24'd1);
    chk("hdr_dw3", hdr_dw3, 32'h1243);
    chk("hdr_dw4", hdr_dw4, 32'ha60);
    chk("hdr_dw7", hdr_dw7, 32'h80000000);
    retire_valid <= 1'b1;
    @(posedge mclk);
    retire_valid <= 1'b0;
    sp(9'd2, 24'd2);
    finish_test();
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    fails++;
    finish_test();
  end
endmodule // domain_stage_push_constant_decode_tb_top
